// ===== design/irq_regs_pkg.sv
package irq_regs_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] enable_main_addr = 8'ha8;
   localparam logic [7:0] prio_main_addr = 8'hb8;
   localparam logic [7:0] enable_ext_one_addr = 8'he6;
   localparam logic [7:0] enable_ext_two_addr = 8'he7;
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int global_enable_bit = 7;
   localparam int timer_two_bit = 5;
   localparam int comparator_bit = 5;
   localparam int adc_window_bit = 2;
   localparam logic [7:0] enable_main_reset = 8'h00;
   localparam logic [7:0] prio_main_reset = 8'h80;
   localparam logic [7:0] prio_unused_mask = 8'h80;
   localparam logic [7:0] ext_one_reset = 8'h00;
   localparam logic [7:0] ext_one_mask = 8'h3f;
   localparam logic [7:0] ext_two_reset = 8'h00;
   localparam logic [7:0] ext_two_mask = 8'h03;
   // ----------------------------------------------------------------
   // source count: index 0..12 then capsense done 13, greater 14
   // ----------------------------------------------------------------
   localparam int num_sources = 15;
   localparam logic [3:0] no_source = 4'hf;
endpackage

// ===== design/irq_priority_pick.sv
// fixed-order pick: lowest index wins within a level
module irq_priority_pick #(
   parameter int width = 15
) (
   input wire logic [width-1:0] req, // enabled requests
   input wire logic [width-1:0] prio, // per source level, 1 = high
   output logic found, // any request present
   output logic found_high, // chosen one is high level
   output logic [3:0] index // chosen source
);
   logic [width-1:0] high_req;
   always_comb begin
      high_req = req & prio;
      found = 1'b0;
      found_high = 1'b0;
      index = 4'h0;
      for (int i = width - 1; i >= 0; i--) begin
         if (req[i]) begin
            found = 1'b1;
            index = 4'(i);
         end
      end
      // high level overrides whatever low pick was made
      for (int i = width - 1; i >= 0; i--) begin
         if (high_req[i]) begin
            found_high = 1'b1;
            index = 4'(i);
         end
      end
   end
endmodule

// ===== design/interrupt_enable_priority_regs.sv
// What this block does
// [R1] global enable low blocks all sources; high leaves each to its own mask
// [R2] main enable register at 0xa8, bits 6..0 per source, bit write allowed
// [R3] timer two enable passes either low-byte or high-byte overflow flag
// [R4] main priority register at 0xb8; bit 7 reads one, writes ignored
// [R5] priority bits 6..0 choose low (0) or high (1) level per source
// [R6] first extended enable at 0xe6, bits 5..0; reserved bits written zero
// [R7] comparator enable passes both rising and falling edge flags
// [R8] adc window enable passes the window compare flag
// [R9] second extended enable at 0xe7; bits 7..2 read zero, writes ignored
// [R10] pending requests sampled and decoded every clock cycle
// [R11] higher level first; equal levels by fixed source order
// [R12] high preempts low service; high service never preempted
// [R13] all enables and priorities reset to zero, unused priority bit reads one
// [R14] request reaches cpu only with flag, own enable and global enable set
module interrupt_enable_priority_regs (
   input wire logic clock, // system clock
   input wire logic sys_rst, // async reset, active high
   input wire logic [7:0] sfr_addr, // register address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic sfr_wr, // byte write strobe
   input wire logic sfr_bit_wr, // single-bit write strobe
   input wire logic [2:0] sfr_bit_sel, // bit number for bit write
   input wire logic sfr_bit_val, // bit value for bit write
   output logic [7:0] sfr_rdata, // registered read data
   input wire logic ext_irq_pin_zero, // external input 0 pending
   input wire logic timer_zero_overflow_flag, // timer 0 pending
   input wire logic ext_irq_pin_one, // external input 1 pending
   input wire logic timer_one_overflow_flag, // timer 1 pending
   input wire logic uart_flag, // uart unit pending
   input wire logic timer_two_low_overflow_flag, // timer 2 low byte
   input wire logic timer_two_high_overflow_flag, // timer 2 high byte
   input wire logic serial_periph_flag, // serial periph unit pending
   input wire logic smbus_flag, // smbus unit pending
   input wire logic port_match_flag, // port match pending
   input wire logic adc_window_flag, // adc window compare
   input wire logic adc_done_flag, // adc conversion done
   input wire logic counter_array_flag, // counter array unit pending
   input wire logic comparator_rise_flag, // comparator rising edge
   input wire logic comparator_fall_flag, // comparator falling edge
   input wire logic capsense_done_flag, // capsense conversion done
   input wire logic capsense_greater_flag, // capsense greater than
   input wire logic service_start, // cpu enters chosen routine
   input wire logic service_return, // cpu returns from routine
   output logic irq_req, // request to cpu core
   output logic irq_req_high, // request is of high level
   output logic [3:0] irq_index, // source order of request
   output logic [14:0] irq_gated // enabled pending sources
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] enable_main, next_enable_main;
   logic [7:0] prio_main, next_prio_main;
   logic [7:0] enable_ext_one, next_enable_ext_one;
   logic [7:0] enable_ext_two, next_enable_ext_two;
   logic [7:0] next_sfr_rdata;
   logic [7:0] bit_mask;

   always_comb begin
      bit_mask = 8'h01 << sfr_bit_sel;
      next_enable_main = enable_main;
      next_prio_main = prio_main;
      next_enable_ext_one = enable_ext_one;
      next_enable_ext_two = enable_ext_two;
      if (sfr_wr) begin
         case (sfr_addr)
            irq_regs_pkg::enable_main_addr: next_enable_main = sfr_wdata; // [R2]
            irq_regs_pkg::prio_main_addr:
               next_prio_main = sfr_wdata | irq_regs_pkg::prio_unused_mask; // [R4] [R5]
            // reserved bits not stored; software must write them zero
            irq_regs_pkg::enable_ext_one_addr:
               next_enable_ext_one = sfr_wdata & irq_regs_pkg::ext_one_mask; // [R6]
            irq_regs_pkg::enable_ext_two_addr:
               next_enable_ext_two = sfr_wdata & irq_regs_pkg::ext_two_mask; // [R9]
            default: ;
         endcase
      end else if (sfr_bit_wr) begin
         // only the two bit-addressable registers take bit writes
         case (sfr_addr)
            irq_regs_pkg::enable_main_addr:
               next_enable_main = sfr_bit_val ? (enable_main | bit_mask)
                                              : (enable_main & ~bit_mask); // [R2]
            irq_regs_pkg::prio_main_addr:
               next_prio_main = (sfr_bit_val ? (prio_main | bit_mask)
                                             : (prio_main & ~bit_mask))
                                | irq_regs_pkg::prio_unused_mask; // [R4]
            default: ;
         endcase
      end
   end

   always_comb begin
      case (sfr_addr)
         irq_regs_pkg::enable_main_addr: next_sfr_rdata = enable_main;
         irq_regs_pkg::prio_main_addr: next_sfr_rdata = prio_main; // [R4]
         irq_regs_pkg::enable_ext_one_addr: next_sfr_rdata = enable_ext_one;
         irq_regs_pkg::enable_ext_two_addr: next_sfr_rdata = enable_ext_two; // [R9]
         default: next_sfr_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         enable_main <= irq_regs_pkg::enable_main_reset; // [R13]
         prio_main <= irq_regs_pkg::prio_main_reset; // [R13]
         enable_ext_one <= irq_regs_pkg::ext_one_reset; // [R13]
         enable_ext_two <= irq_regs_pkg::ext_two_reset; // [R13]
         sfr_rdata <= 8'h00;
      end else begin
         enable_main <= next_enable_main;
         prio_main <= next_prio_main;
         enable_ext_one <= next_enable_ext_one;
         enable_ext_two <= next_enable_ext_two;
         sfr_rdata <= next_sfr_rdata;
      end
   end

   // ----------------------------------------------------------------
   // source gating
   // ----------------------------------------------------------------
   logic global_irq_enable;
   logic [14:0] pending, own_enable, gated, prio_vec;

   always_comb begin
      global_irq_enable = enable_main[irq_regs_pkg::global_enable_bit];
      pending = {capsense_greater_flag, capsense_done_flag,
                 comparator_rise_flag | comparator_fall_flag, // [R7]
                 counter_array_flag, adc_done_flag,
                 adc_window_flag, // [R8]
                 port_match_flag, smbus_flag, serial_periph_flag,
                 timer_two_low_overflow_flag | timer_two_high_overflow_flag, // [R3]
                 uart_flag, timer_one_overflow_flag, ext_irq_pin_one,
                 timer_zero_overflow_flag, ext_irq_pin_zero};
      own_enable = {enable_ext_two[1], enable_ext_two[0],
                    enable_ext_one[irq_regs_pkg::comparator_bit],
                    enable_ext_one[3], enable_ext_one[4],
                    enable_ext_one[irq_regs_pkg::adc_window_bit],
                    enable_ext_one[1], enable_ext_one[0],
                    enable_main[6],
                    enable_main[irq_regs_pkg::timer_two_bit],
                    enable_main[4:0]};
      gated = global_irq_enable ? (pending & own_enable) : 15'h0000; // [R1] [R14]
      // extended sources held at low level; their priority regs live elsewhere
      prio_vec = {8'h00, prio_main[6:0]}; // [R5]
   end

   // ----------------------------------------------------------------
   // priority decode and preemption
   // ----------------------------------------------------------------
   logic pick_found, pick_high;
   logic [3:0] pick_index;

   irq_priority_pick #(
      .width(irq_regs_pkg::num_sources)
   ) u_pick (
      .req(gated),
      .prio(prio_vec),
      .found(pick_found),
      .found_high(pick_high),
      .index(pick_index)
   );

   // depth of nesting: in_low low routine active, in_high high routine active
   logic in_low, next_in_low, in_high, next_in_high;
   logic allow, next_irq_req, next_irq_req_high;
   logic [3:0] next_irq_index;

   always_comb begin
      next_in_low = in_low;
      next_in_high = in_high;
      if (service_start && irq_req) begin
         if (irq_req_high) next_in_high = 1'b1;
         else next_in_low = 1'b1;
      end else if (service_return) begin
         // return leaves the innermost routine first
         if (in_high) next_in_high = 1'b0;
         else next_in_low = 1'b0;
      end
      // high routine blocks all; low routine yields only to high
      allow = !in_high && (!in_low || pick_high); // [R12]
      next_irq_req = pick_found && allow; // [R10] [R11]
      next_irq_req_high = pick_found && allow && pick_high; // [R11]
      next_irq_index = (pick_found && allow) ? pick_index : irq_regs_pkg::no_source;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         in_low <= 1'b0;
         in_high <= 1'b0;
         irq_req <= 1'b0;
         irq_req_high <= 1'b0;
         irq_index <= irq_regs_pkg::no_source;
         irq_gated <= 15'h0000;
      end else begin
         in_low <= next_in_low;
         in_high <= next_in_high;
         irq_req <= next_irq_req; // [R10]
         irq_req_high <= next_irq_req_high;
         irq_index <= next_irq_index;
         irq_gated <= gated; // [R14]
      end
   end
endmodule

// ===== tb/irq_regs_checker_properties.sv
module irq_regs_checker (
   input wire logic clock, // clock
   input wire logic sys_rst, // reset
   input wire logic [7:0] sfr_addr, // address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic sfr_wr, // write strobe
   input wire logic [7:0] sfr_rdata, // read data
   input wire logic timer_two_low_overflow_flag, // t2 low
   input wire logic timer_two_high_overflow_flag, // t2 high
   input wire logic comparator_rise_flag, // rise
   input wire logic comparator_fall_flag, // fall
   input wire logic service_start, // entry
   input wire logic irq_req, // request
   input wire logic irq_req_high, // level
   input wire logic [3:0] irq_index, // source
   input wire logic [14:0] irq_gated // gated
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_global_off;
      sfr_wr && sfr_addr == 8'ha8 && !sfr_wdata[7] |-> ##2 irq_gated == 15'h0000;
   endproperty
   a_global_off: assert property (p_global_off) else $error("global off still gated");
   property p_tim2_pair;
      irq_gated[5] |-> $past(timer_two_low_overflow_flag || timer_two_high_overflow_flag);
   endproperty
   a_tim2_pair: assert property (p_tim2_pair) else $error("timer two without flag");
   property p_cmp_pair;
      irq_gated[12] |-> $past(comparator_rise_flag || comparator_fall_flag);
   endproperty
   a_cmp_pair: assert property (p_cmp_pair) else $error("comparator without flag");
   // read data lags the address by one edge, so skip the edge leaving reset
   property p_prio_top;
      $past(sfr_addr) == 8'hb8 && !$past(sys_rst) |-> sfr_rdata[7];
   endproperty
   a_prio_top: assert property (p_prio_top) else $error("priority bit 7 read low");
   property p_ext_one;
      $past(sfr_addr) == 8'he6 && !$past(sys_rst) |-> sfr_rdata[7:6] == 2'h0;
   endproperty
   a_ext_one: assert property (p_ext_one) else $error("ext one reserved set");
   property p_ext_two;
      $past(sfr_addr) == 8'he7 && !$past(sys_rst) |-> sfr_rdata[7:2] == 6'h00;
   endproperty
   a_ext_two: assert property (p_ext_two) else $error("ext two unused set");
   property p_idle;
      !irq_req |-> irq_index == 4'hf && !irq_req_high;
   endproperty
   a_idle: assert property (p_idle) else $error("idle index wrong");
   property p_pick;
      irq_req |-> irq_gated[irq_index];
   endproperty
   a_pick: assert property (p_pick) else $error("chosen source not gated");
   property p_high_hold;
      service_start && irq_req && irq_req_high |-> ##2 !irq_req;
   endproperty
   a_high_hold: assert property (p_high_hold) else $error("high routine preempted");
   c_high_taken: cover property (service_start && irq_req && irq_req_high);
   c_tim2: cover property (irq_gated[5]);
   c_ext_two: cover property ($past(sfr_addr) == 8'he7);
endmodule

bind interrupt_enable_priority_regs irq_regs_checker irq_regs_checker_i (.*);

// ===== tb/cpu_vector_model.sv
module cpu_vector_model (
   input wire logic clock, // system clock
   input wire logic sys_rst, // reset
   input wire logic irq_req, // request from block
   input wire logic take, // bench asks to enter
   input wire logic give_back, // bench asks to leave
   output logic service_start, // entry pulse
   output logic service_return // exit pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   // core enters only a request that stands at the edge
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         service_start <= 1'b0;
         service_return <= 1'b0;
      end else begin
         service_start <= take && irq_req;
         service_return <= give_back;
      end
   end
endmodule

// ===== tb/interrupt_enable_priority_regs_test.sv
module interrupt_enable_priority_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [2:0] sfr_bit_sel = 3'h0;
   logic [16:0] fl = 17'h00000;
   logic take = 1'b0, give_back = 1'b0, service_start, service_return, irq_req, irq_req_high;
   logic [3:0] irq_index, idx;
   logic [14:0] irq_gated;
   int n_fail = 0, n_tests = 0;
   always #2.5 clock = ~clock;
   cpu_vector_model cpu_vector_model_i (.*);
   interrupt_enable_priority_regs interrupt_enable_priority_regs_i (.*,
      .ext_irq_pin_zero(fl[0]), .timer_zero_overflow_flag(fl[1]), .ext_irq_pin_one(fl[2]),
      .timer_one_overflow_flag(fl[3]), .uart_flag(fl[4]), .timer_two_low_overflow_flag(fl[5]),
      .timer_two_high_overflow_flag(fl[6]), .serial_periph_flag(fl[7]), .smbus_flag(fl[8]),
      .port_match_flag(fl[9]), .adc_window_flag(fl[10]), .adc_done_flag(fl[11]),
      .counter_array_flag(fl[12]), .comparator_rise_flag(fl[13]),
      .comparator_fall_flag(fl[14]), .capsense_done_flag(fl[15]),
      .capsense_greater_flag(fl[16]));
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      settle(1);
      sfr_wr = 1'b0;
   endtask
   task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
      sfr_addr = a;
      sfr_bit_sel = s;
      sfr_bit_val = v;
      sfr_bit_wr = 1'b1;
      settle(1);
      sfr_bit_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      settle(1);
      chk("sfr_rdata", {13'h0000, exp}, {13'h0000, sfr_rdata});
   endtask
   task automatic irq(input logic [20:0] exp);
      chk("irq", exp, {irq_req, irq_req_high, irq_index, irq_gated});
   endtask
   // a one-cycle command to the core model, then time for it to land
   task automatic cpu(input logic ret);
      take = !ret;
      give_back = ret;
      settle(1);
      take = 1'b0;
      give_back = 1'b0;
      settle(2);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      settle(3);
      sys_rst = 1'b0;
      rd(8'ha8, 8'h00);
      rd(8'hb8, 8'h80);
      rd(8'he6, 8'h00);
      rd(8'he7, 8'h00);
      rd(8'h00, 8'h00);
      wr(8'hb8, 8'h7f);
      rd(8'hb8, 8'hff);
      bwr(8'hb8, 3'h7, 1'b0);
      rd(8'hb8, 8'hff);
      bwr(8'hb8, 3'h6, 1'b0);
      rd(8'hb8, 8'hbf);
      wr(8'he7, 8'hff);
      rd(8'he7, 8'h03);
      wr(8'he6, 8'h3f);
      rd(8'he6, 8'h3f);
      bwr(8'he6, 3'h0, 1'b0);
      rd(8'he6, 8'h3f);
      wr(8'ha8, 8'h7f);
      bwr(8'ha8, 3'h7, 1'b1);
      rd(8'ha8, 8'hff);
      wr(8'ha8, 8'h7f);
      fl = 17'h1ffff;
      settle(2);
      irq({6'h0f, 15'h0000});
      bwr(8'ha8, 3'h7, 1'b1);
      settle(2);
      irq({6'h30, 15'h7fff});
      for (int b = 0; b < 7; b++) begin
         wr(8'hb8, 8'h01 << b);
         settle(2);
         irq({2'h3, b[3:0], 15'h7fff});
      end
      wr(8'hb8, 8'h00);
      fl = 17'h1fff0;
      settle(2);
      irq({6'h24, 15'h7ff0});
      for (int i = 0; i < 17; i++) begin
         fl = 17'h00001 << i;
         idx = 4'(i - (i > 5) - (i > 13));
         settle(2);
         irq({2'h2, idx, 15'h0001 << idx});
      end
      wr(8'he7, 8'h02);
      fl = 17'h08000;
      settle(2);
      irq({6'h0f, 15'h0000});
      wr(8'hb8, 8'h02);
      fl = 17'h00001;
      settle(2);
      irq({6'h20, 15'h0001});
      cpu(1'b0);
      irq({6'h0f, 15'h0001});
      fl = 17'h00003;
      settle(2);
      irq({6'h31, 15'h0003});
      cpu(1'b0);
      irq({6'h0f, 15'h0003});
      cpu(1'b1);
      irq({6'h31, 15'h0003});
      fl = 17'h00001;
      cpu(1'b1);
      irq({6'h20, 15'h0001});
      // second reset in mid-run: every register back to its reset value
      sys_rst = 1'b1;
      settle(1);
      sys_rst = 1'b0;
      rd(8'ha8, 8'h00);
      rd(8'hb8, 8'h80);
      rd(8'he6, 8'h00);
      rd(8'he7, 8'h00);
      irq({6'h0f, 15'h0000});
      report_and_stop();
   end
endmodule
